// file: logic/vmo_pkg.sv
// shared constants and types for the memory-operand execution block
package vmo_pkg;

  //----------------------------------------------------------------
  // widths
  //----------------------------------------------------------------
  localparam int DW  = 32;
  localparam int MAW = 6;
  localparam int BAW = 12;
  localparam int NREF = 16;

  //----------------------------------------------------------------
  // instruction word fields
  //----------------------------------------------------------------
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 24;
  localparam int CC_HI  = 23;
  localparam int CC_LO  = 20;
  localparam int DST_HI = 15;
  localparam int DST_LO = 12;
  localparam int S1_HI  = 7;
  localparam int S1_LO  = 4;
  localparam int S0_HI  = 3;
  localparam int S0_LO  = 0;

  localparam logic [7:0] OP_TEST  = 8'h3F;
  localparam logic [7:0] OP_CLMUL = 8'h32;
  localparam logic [7:0] OP_UNSIGNED_MULTIPLY_OP  = 8'h33;
  localparam logic [7:0] OP_ADD   = 8'h36;

  // condition selector codes
  localparam logic [3:0] CC_ALWAYS = 4'h0;
  localparam logic [3:0] CC_ZERO   = 4'h1;
  localparam logic [3:0] CC_NZERO  = 4'h2;
  localparam logic [3:0] CC_CARRY  = 4'h3;
  localparam logic [3:0] CC_NCARRY = 4'h4;
  localparam logic [3:0] CC_EVEN   = 4'h5;
  localparam logic [3:0] CC_ODD    = 4'h6;
  localparam logic [3:0] CC_ONE    = 4'h7;
  localparam logic [3:0] CC_NONE   = 4'h8;

  //----------------------------------------------------------------
  // register map
  //----------------------------------------------------------------
  localparam logic [BAW-1:0] A_STATUS = 12'h000;
  localparam logic [BAW-1:0] A_CTRL   = 12'h004;
  localparam logic [BAW-1:0] A_DESC   = 12'h040;
  localparam logic [BAW-1:0] A_MEM    = 12'h100;
  localparam logic           CTRL_RST = 1'b1;
  localparam logic [1:0]     RESP_OK  = 2'h0;
  localparam logic [1:0]     RESP_ERR = 2'h2;

  //----------------------------------------------------------------
  // types
  //----------------------------------------------------------------
  typedef struct packed {
    logic one;
    logic zero;
    logic even;
    logic carry;
  } vmo_flags_s;

  typedef struct packed {
    logic [4:0]     size_m1;
    logic [MAW-1:0] addr;
  } vmo_desc_s;

  localparam vmo_desc_s DESC_RST = '0;

  // low-bit mask for an operand of size_m1 + 1 bits
  function automatic logic [DW-1:0] vmo_mask(input logic [4:0] m);
    return 32'hFFFFFFFF >> (5'h1F - m);
  endfunction

endpackage

// file: logic/vmo_opmem.sv
// operand memory buffer with byte lanes and registered read data
`timescale 1ns/100ps
module vmo_opmem (
  // clock
  input  wire  logic                      clock,
  // access port
  input  wire  logic [vmo_pkg::MAW-1:0]   addr,
  input  wire  logic [3:0]                we,
  input  wire  logic [vmo_pkg::DW-1:0]    wdata,
  output logic       [vmo_pkg::DW-1:0]    rdata
);
  import vmo_pkg::*;

  genvar b;
  for (b = 0; b < 4; b++) begin : g_lane
    logic [7:0] lane [2**MAW];
    always_ff @(posedge clock) begin
      if (we[b]) begin
        lane[addr] <= wdata[8*b +: 8];
      end
      rdata[8*b +: 8] <= lane[addr];
    end
  end

endmodule // vmo_opmem

// file: logic/vmo_exec.sv
// execution datapath for memory-operand test, multiply and add
`timescale 1ns/100ps
//------------------------------------------------------------------
//------------------------------------------------------------------
module vmo_exec (
  // clock and reset
  input  wire  logic                      clock,
  input  wire  logic                      reset_n,
  // instruction issue
  input  wire  logic                      instr_valid,
  input  wire  logic [31:0]               instruction_word,
  output logic                            instr_ready,
  output logic                            instr_done,
  output logic                            instr_executed,
  output vmo_pkg::vmo_flags_s             status_flags,
  // axi4-lite slave
  input  wire  logic                      s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire  logic [vmo_pkg::BAW-1:0]   s_axi_awaddr,
  input  wire  logic                      s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire  logic [31:0]               s_axi_wdata,
  input  wire  logic [3:0]                s_axi_wstrb,
  output logic                            s_axi_bvalid,
  input  wire  logic                      s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  input  wire  logic                      s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire  logic [vmo_pkg::BAW-1:0]   s_axi_araddr,
  output logic                            s_axi_rvalid,
  input  wire  logic                      s_axi_rready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp
);
  import vmo_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_RD0, S_RD1, S_CAP, S_MUL, S_WB} vmo_state_e;

  vmo_state_e         state_reg;
  vmo_flags_s         flags_reg;
  vmo_desc_s          desc_reg [NREF];
  vmo_desc_s          dst_reg, s0_reg, s1_reg;
  logic [7:0]         op_reg;
  logic [4:0]         isz_reg;
  logic [DW-1:0]      op0_reg, op1_reg, acc_reg;
  logic [4:0]         cnt_reg;
  logic               ctrl_en_reg;
  logic [BAW-1:0]     awaddr_reg, araddr_reg;
  logic [31:0]        wdata_reg;
  logic [3:0]         wstrb_reg;
  logic               ar_wait_reg;
  logic               accept, run_c, wr_go, rd_go, rd_pend, mul_last;
  logic [DW:0]        sum_c;
  logic [DW-1:0]      res_c, mem_rdata, mem_wdata, reg_rdata;
  logic [MAW-1:0]     mem_addr;
  logic [3:0]         mem_we;
  logic               add_ovf, res_lsb;

  //----------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------
  function automatic logic cond_true(input logic [3:0] sel, input vmo_flags_s f);
    logic r;
    case (sel)
      CC_ALWAYS: r = 1'b1;
      CC_ZERO:   r = f.zero;
      CC_NZERO:  r = !f.zero;
      CC_CARRY:  r = f.carry;
      CC_NCARRY: r = !f.carry;
      CC_EVEN:   r = f.even;
      CC_ODD:    r = !f.even;
      CC_ONE:    r = f.one;
      CC_NONE:   r = !f.one;
      default:   r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic is_known(input logic [7:0] op);
    return op == OP_TEST || op == OP_CLMUL || op == OP_UNSIGNED_MULTIPLY_OP || op == OP_ADD;
  endfunction

  // zero-extend to source size, then cut to instruction size
  function automatic logic [DW-1:0] resize(input logic [DW-1:0] d,
                                           input logic [4:0] src_m1,
                                           input logic [4:0] isz_m1);
    return d & vmo_mask(src_m1) & vmo_mask(isz_m1);
  endfunction

  function automatic logic is_mem(input logic [BAW-1:0] a);
    return a[BAW-1:8] == A_MEM[BAW-1:8];
  endfunction

  function automatic logic is_desc(input logic [BAW-1:0] a);
    return a[BAW-1:6] == A_DESC[BAW-1:6];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  //----------------------------------------------------------------
  // decode and sequencing
  //----------------------------------------------------------------
  assign accept = instr_valid && instr_ready;
  assign run_c  = cond_true(instruction_word[CC_HI:CC_LO], flags_reg)
               && is_known(instruction_word[OPC_HI:OPC_LO]);
  assign mul_last = cnt_reg == isz_reg || (op0_reg >> cnt_reg) <= 32'h1;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
    end else begin
      unique case (state_reg)
        S_IDLE: if (accept && run_c) state_reg <= S_RD0;
        S_RD0:  state_reg <= S_RD1;
        S_RD1:  state_reg <= (op_reg == OP_TEST) ? S_WB : S_CAP;
        S_CAP:  state_reg <= (op_reg == OP_ADD) ? S_WB : S_MUL;
        S_MUL:  if (mul_last) state_reg <= S_WB;
        S_WB:   state_reg <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      op_reg  <= 8'h00;
      isz_reg <= 5'h00;
      dst_reg <= DESC_RST;
      s0_reg  <= DESC_RST;
      s1_reg  <= DESC_RST;
    end else if (accept) begin
      op_reg  <= instruction_word[OPC_HI:OPC_LO];
      dst_reg <= desc_reg[instruction_word[DST_HI:DST_LO]];
      s1_reg  <= desc_reg[instruction_word[S1_HI:S1_LO]];
      s0_reg  <= desc_reg[instruction_word[S0_HI:S0_LO]];
      if (instruction_word[OPC_HI:OPC_LO] == OP_TEST) begin
        isz_reg <= desc_reg[instruction_word[S0_HI:S0_LO]].size_m1;
      end else begin
        isz_reg <= desc_reg[instruction_word[DST_HI:DST_LO]].size_m1;
      end
    end
  end

  //----------------------------------------------------------------
  // operand capture and multiply
  //----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      op0_reg <= '0;
      op1_reg <= '0;
    end else if (state_reg == S_RD1) begin
      op0_reg <= resize(mem_rdata, s0_reg.size_m1, isz_reg);
    end else if (state_reg == S_CAP) begin
      op1_reg <= resize(mem_rdata, s1_reg.size_m1, isz_reg);
    end
  end

  // shift-and-add over the second source bits, stops at its top set bit
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg <= '0;
      cnt_reg <= 5'h00;
    end else if (state_reg == S_CAP) begin
      acc_reg <= '0;
      cnt_reg <= 5'h00;
    end else if (state_reg == S_MUL) begin
      cnt_reg <= cnt_reg + 5'h01;
      if (op0_reg[cnt_reg]) begin
        if (op_reg == OP_CLMUL) begin
          acc_reg <= acc_reg ^ (op1_reg << cnt_reg);
        end else begin
          acc_reg <= acc_reg + (op1_reg << cnt_reg);
        end
      end
    end
  end

  always_comb begin
    sum_c   = {1'b0, op1_reg} + {1'b0, op0_reg};
    add_ovf = sum_c > {1'b0, vmo_mask(isz_reg)};
    if (op_reg == OP_TEST) begin
      res_c = op0_reg;
    end else if (op_reg == OP_ADD) begin
      res_c = sum_c[DW-1:0] & vmo_mask(isz_reg);
    end else begin
      res_c = acc_reg & vmo_mask(isz_reg);
    end
    res_lsb = res_c[0];
  end

  //----------------------------------------------------------------
  // status flags and completion
  //----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= '0;
    end else if (state_reg == S_WB) begin
      flags_reg.even <= !res_c[0];
      flags_reg.zero <= res_c == 32'h0;
      flags_reg.one  <= res_c == 32'h1;
      if (op_reg == OP_TEST) begin
        flags_reg.carry <= 1'b0;
      end else if (op_reg == OP_ADD) begin
        flags_reg.carry <= add_ovf;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      instr_ready    <= 1'b0;
      instr_done     <= 1'b0;
      instr_executed <= 1'b0;
    end else begin
      instr_ready    <= ctrl_en_reg && (state_reg == S_WB ||
                        (state_reg == S_IDLE && !(accept && run_c)));
      instr_done     <= state_reg == S_WB || (accept && !run_c);
      instr_executed <= state_reg == S_WB;
    end
  end

  assign status_flags = flags_reg;

  //----------------------------------------------------------------
  // operand memory port
  //----------------------------------------------------------------
  always_comb begin
    mem_addr  = araddr_reg[MAW+1:2];
    mem_we    = 4'h0;
    mem_wdata = wdata_reg;
    unique case (state_reg)
      S_RD0:  mem_addr = s0_reg.addr;
      S_RD1:  mem_addr = s1_reg.addr;
      S_WB: begin
        mem_addr  = dst_reg.addr;
        mem_wdata = res_c;
        if (op_reg != OP_TEST) mem_we = 4'hF;
      end
      default: begin
        if (wr_go && is_mem(awaddr_reg)) begin
          mem_addr = awaddr_reg[MAW+1:2];
          mem_we   = wstrb_reg;
        end
      end
    endcase
  end

  vmo_opmem u_mem (
    .clock (clock),
    .addr  (mem_addr),
    .we    (mem_we),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  //----------------------------------------------------------------
  // axi4-lite write
  //----------------------------------------------------------------
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid
              && (!is_mem(awaddr_reg) || state_reg == S_IDLE);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_reg    <= s_axi_awaddr;
      end else if (wr_go) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
      end else if (wr_go) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_reg == A_STATUS || awaddr_reg == A_CTRL ||
                       is_desc(awaddr_reg) || is_mem(awaddr_reg)) ? RESP_OK : RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_en_reg <= CTRL_RST;
      for (int i = 0; i < NREF; i++) desc_reg[i] <= DESC_RST;
    end else if (wr_go) begin
      if (awaddr_reg == A_CTRL && wstrb_reg[0]) begin
        ctrl_en_reg <= wdata_reg[0];
      end
      if (is_desc(awaddr_reg)) begin
        desc_reg[awaddr_reg[5:2]] <= vmo_desc_s'(11'(merge(32'(desc_reg[awaddr_reg[5:2]]),
                                                           wdata_reg, wstrb_reg)));
      end
    end
  end

  //----------------------------------------------------------------
  // axi4-lite read
  //----------------------------------------------------------------
  assign rd_pend = !s_axi_arready && !s_axi_rvalid;
  assign rd_go   = rd_pend && is_mem(araddr_reg) && !ar_wait_reg
                && state_reg == S_IDLE && !(wr_go && is_mem(awaddr_reg));

  always_comb begin
    reg_rdata = 32'h0;
    if (araddr_reg == A_STATUS) begin
      reg_rdata = {27'h0, state_reg != S_IDLE, flags_reg};
    end else if (araddr_reg == A_CTRL) begin
      reg_rdata = {31'h0, ctrl_en_reg};
    end else if (is_desc(araddr_reg)) begin
      reg_rdata = {21'h0, desc_reg[araddr_reg[5:2]]};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      araddr_reg    <= '0;
      ar_wait_reg   <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OK;
    end else begin
      ar_wait_reg <= rd_go;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        araddr_reg    <= s_axi_araddr;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (ar_wait_reg) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= mem_rdata;
        s_axi_rresp  <= RESP_OK;
      end else if (rd_pend && !is_mem(araddr_reg)) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= reg_rdata;
        s_axi_rresp  <= (araddr_reg == A_STATUS || araddr_reg == A_CTRL ||
                         is_desc(araddr_reg)) ? RESP_OK : RESP_ERR;
      end
    end
  end

  //----------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_fetch;
    state_reg == S_RD0 ##1 state_reg == S_RD1;
  endsequence

  sequence s_mul_run;
    state_reg == S_MUL ##[1:32] state_reg == S_WB;
  endsequence

  a_accept_fetch: assert property (accept && run_c |=> s_fetch)
    else $error("accepted instruction did not fetch");
  a_skip_false: assert property (accept && !run_c |=>
                  state_reg == S_IDLE && instr_done && !instr_executed)
    else $error("false condition still acted");
  a_test_nowrite: assert property (state_reg == S_WB && op_reg == OP_TEST |->
                    mem_we == 4'h0)
    else $error("test wrote a destination");
  a_test_carry: assert property (state_reg == S_WB && op_reg == OP_TEST |=>
                  !flags_reg.carry)
    else $error("test left carry set");
  a_flag_even: assert property (state_reg == S_WB |=>
                 flags_reg.even == !$past(res_lsb) &&
                 flags_reg.zero == ($past(res_c) == 32'h0))
    else $error("even or zero flag wrong");
  a_add_carry: assert property (state_reg == S_WB && op_reg == OP_ADD |=>
                 flags_reg.carry == $past(add_ovf))
    else $error("add carry wrong");
  a_wb_masked: assert property (state_reg == S_WB && mem_we == 4'hF |->
                 (mem_wdata & ~vmo_mask(isz_reg)) == 32'h0)
    else $error("writeback exceeds instruction size");
  a_mul_bound: assert property (state_reg == S_CAP && op_reg != OP_ADD |=>
                 s_mul_run)
    else $error("multiply did not finish in time");
  a_ready_idle: assert property (instr_ready |-> state_reg == S_IDLE)
    else $error("ready while busy");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

endmodule // vmo_exec

// file: sim/vmo_issue_model.sv
// issue queue model: offers one instruction word at a time
`timescale 1ns/100ps
module vmo_issue_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // bench request
  input  wire logic        go,
  input  wire logic [31:0] word,
  // issue port
  input  wire logic        instr_ready,
  output logic             instr_valid,
  output logic [31:0]      instruction_word
);
  // hold the offer until taken, then scramble the released word
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      instr_valid      <= 1'b0;
      instruction_word <= 32'h0;
    end else if (go) begin
      instr_valid      <= 1'b1;
      instruction_word <= word;
    end else if (instr_valid && instr_ready) begin
      instr_valid      <= 1'b0;
      instruction_word <= ~instruction_word;
    end
  end
endmodule // vmo_issue_model

// file: sim/tb.sv
// self-checking bench for the memory-operand execution block
`timescale 1ns/100ps
module tb;
  import vmo_pkg::*;
  //----------------------------------------------------------------
  // signals
  //----------------------------------------------------------------
  logic           clock   = 1'b0;
  logic           reset_n = 1'b0;
  logic           go      = 1'b0;
  logic [31:0]    word    = 32'h0;
  logic           awvalid = 1'b0;
  logic           wvalid  = 1'b0;
  logic           bready  = 1'b0;
  logic           arvalid = 1'b0;
  logic           rready  = 1'b0;
  logic [BAW-1:0] awaddr  = '0;
  logic [BAW-1:0] araddr  = '0;
  logic [31:0]    wdata   = 32'h0;
  logic           instr_valid, instr_ready, instr_done, instr_executed;
  logic [31:0]    instruction_word, rdata, got;
  logic           awready, wready, bvalid, arready, rvalid;
  logic [1:0]     bresp, rresp, resp;
  vmo_flags_s     status_flags;
  logic [3:0]     fl = 4'h0;
  logic [7:0]     ops [8] = '{OP_TEST, OP_CLMUL, OP_UNSIGNED_MULTIPLY_OP, OP_ADD, OP_TEST, OP_ADD, OP_UNSIGNED_MULTIPLY_OP, 8'h30};
  int             seed = 72;
  int             miscompares = 0;
  int             num_checks = 0;

  always #5 clock = ~clock;

  vmo_issue_model i_vmo_issue_model (.clock(clock), .reset_n(reset_n), .go(go), .word(word),
    .instr_ready(instr_ready), .instr_valid(instr_valid), .instruction_word(instruction_word));

  vmo_exec i_vmo_exec (.clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
    .instruction_word(instruction_word), .instr_ready(instr_ready), .instr_done(instr_done),
    .instr_executed(instr_executed), .status_flags(status_flags),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  //----------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wrap_up;
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    if (bvalid !== 1'b1) miscompares++;
    bready <= 1'b0;
    r = bresp;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    if (rvalid !== 1'b1) miscompares++;
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  function automatic logic [31:0] msk(input logic [4:0] m);
    return 32'hFFFFFFFF >> (5'd31 - m);
  endfunction

  function automatic logic [11:0] ra(input logic [3:0] r);
    return {6'h0, r, 2'h0};
  endfunction

  // condition selector against flags {one, zero, even, carry}
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    case (c)
      CC_ALWAYS: return 1'b1;
      CC_ZERO:   return f[2];
      CC_NZERO:  return !f[2];
      CC_CARRY:  return f[0];
      CC_NCARRY: return !f[0];
      CC_EVEN:   return f[1];
      CC_ODD:    return !f[1];
      CC_ONE:    return f[3];
      CC_NONE:   return !f[3];
      default:   return 1'b0;
    endcase
  endfunction

  // sizes packed {dest, first, second}, each size minus one
  task automatic run_op(input logic [7:0] op, input logic [3:0] cc, input logic [14:0] sz,
                        input logic [31:0] a, input logic [31:0] b);
    logic [3:0]  d, s1, s2;
    logic [4:0]  isz;
    logic [31:0] x, y, res, old, iw;
    logic [63:0] p;
    logic        run;
    int          n;
    d   = 4'($random(seed));
    s1  = d + 4'h1 + 4'($random(seed) & 3);
    s2  = s1 + 4'h4;
    old = $random(seed);
    axi_wr(A_DESC + ra(d), {21'h0, sz[14:10], 2'h0, d}, resp);
    axi_wr(A_DESC + ra(s1), {21'h0, sz[9:5], 2'h0, s1}, resp);
    axi_wr(A_DESC + ra(s2), {21'h0, sz[4:0], 2'h0, s2}, resp);
    axi_wr(A_MEM + ra(d), old, resp);
    axi_wr(A_MEM + ra(s1), a, resp);
    axi_wr(A_MEM + ra(s2), b, resp);
    isz = (op == OP_TEST) ? sz[4:0] : sz[14:10];
    x   = a & msk(sz[9:5]) & msk(isz);
    y   = b & msk(sz[4:0]) & msk(isz);
    p   = 64'(y);
    if (op == OP_UNSIGNED_MULTIPLY_OP) p = 64'(x) * 64'(y);
    if (op == OP_ADD) p = 64'(x) + 64'(y);
    if (op == OP_CLMUL) begin
      p = 64'h0;
      for (int i = 0; i < 32; i++) if (y[i]) p = p ^ (64'(x) << i);
    end
    res = p[31:0] & msk(isz);
    run = cond_ok(cc, fl) && (op inside {OP_TEST, OP_CLMUL, OP_UNSIGNED_MULTIPLY_OP, OP_ADD});
    if (run) begin
      fl[1] = !res[0];
      fl[2] = (res == 32'h0);
      fl[3] = (res == 32'h1);
      if (op == OP_TEST) fl[0] = 1'b0;
      if (op == OP_ADD) fl[0] = ((p >> (isz + 1)) != 64'h0);
    end
    iw = {op, cc, 20'($random(seed))};
    iw[3:0] = s2;
    if (op != OP_TEST) iw[15:12] = d;
    if (op != OP_TEST) iw[7:4] = s1;
    repeat ($random(seed) & 3) @(posedge clock);
    @(posedge clock);
    go   <= 1'b1;
    word <= iw;
    @(posedge clock);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (instr_done !== 1'b1 && n < 100);
    if (instr_done !== 1'b1) miscompares++;
    chk(32'(instr_executed), 32'(run));
    chk(32'(status_flags), 32'(fl));
    axi_rd(A_MEM + ra(d), got, resp);
    if (run && op != OP_TEST) chk(got & msk(isz), res);
    else chk(got, old);
    axi_rd(A_STATUS, got, resp);
    chk(got, {28'h0, fl});
  endtask

  //----------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    run_op(OP_ADD, CC_ALWAYS, {5'd31, 5'd31, 5'd31}, 32'hFFFFFFFF, 32'h1);
    run_op(OP_UNSIGNED_MULTIPLY_OP, CC_CARRY, {5'd7, 5'd15, 5'd3}, 32'h1234, 32'hFF);
    run_op(OP_TEST, CC_ALWAYS, 15'h0, 32'h0, 32'h3);
    run_op(OP_CLMUL, CC_ONE, {5'd31, 5'd31, 5'd31}, 32'h87654321, 32'hFFFFFFFF);
    run_op(8'h37, CC_ALWAYS, 15'h7FFF, 32'h5, 32'h6);
    for (int c = 0; c < 16; c++) run_op(OP_ADD, 4'(c), 15'($random(seed)), $random(seed),
                                        $random(seed));
    axi_wr(A_STATUS, 32'hF, resp);
    chk(32'(resp), 32'(RESP_OK));
    axi_rd(A_STATUS, got, resp);
    chk(got, {28'h0, fl});
    axi_wr(A_CTRL, 32'h0, resp);
    axi_rd(A_CTRL, got, resp);
    chk(got, 32'h0);
    chk(32'(instr_ready), 32'h0);
    axi_wr(A_CTRL, 32'h1, resp);
    axi_wr(12'h200, 32'h1, resp);
    chk(32'(resp), 32'(RESP_ERR));
    axi_rd(12'h200, got, resp);
    chk(32'(resp), 32'(RESP_ERR));
    for (int k = 0; k < 50; k++)
      run_op(ops[$random(seed) & 7], ($random(seed) & 1) ? CC_ALWAYS : 4'($random(seed)),
             15'($random(seed)), $random(seed), $random(seed));
    wrap_up();
  end

  initial begin
    #500000;
    miscompares++;
    wrap_up();
  end
endmodule // tb
